/* File: design/iosd_slot_diag.sv */
`timescale 1ns/1ns
// Notes on behaviour
// [RULE1] Two-channel digital: data bits 0, 1
// [RULE2] Counter: state 0, invalid 1, direction 3
// [RULE3] Analog in byte one: channels 1, 2
// [RULE4] Analog in byte two: channels 3, 4
// [RULE5] Outputs report invalid bits 1, 5 only
// [RULE6] Second byte only for dual-width modules
// [RULE7] Absent channels read as reserved zero; counter bits are not masked by chan_cnt
// [RULE8] Type pair: configured then plugged identifier
// [RULE9] Identifier: family digit, then type number
// [RULE10] Reader compares pair, mismatch needs action
// [RULE11] Per-slot mismatch flag from pair compare
module iosd_slot_diag
	import iosd_pkg::*;
#(
	parameter int NSLOTS = 8
) (
	input  wire logic                    clock,
	input  wire logic                    rst_n,
	input  wire logic [ADDR_W-1:0]       addr,
	input  wire logic [DATA_W-1:0]       wdata,
	input  wire logic                    wr_stb,
	input  wire logic                    rd_stb,
	output logic      [DATA_W-1:0]       rdata,
	input  wire iosd_raw_s [NSLOTS-1:0]  slot_raw,
	output logic      [NSLOTS-1:0]       slot_mismatch,
	output logic                         irq
);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [ADDR_W-1:0] slot_addr(input int s, input logic [11:0] r);
		slot_addr = ADDR_W'(OFF_SLOT_BASE + (ADDR_W'(s) << SLOT_SH) + r);
	endfunction

	// The family is taken from the configured identifier, so the layout
	// never jumps while a wrong module is plugged in
	function automatic iosd_fam_e fam_of(input logic [7:0] id);
		logic [3:0] hi;
		logic [3:0] lo;
		hi = id[7:4];
		lo = id[3:0];
		if (hi == HI_DIG2 && lo == LO_DIG2) begin // [RULE9]
			fam_of = FAM_DIG2;
		end else if (hi == HI_CNT && lo == LO_CNT) begin
			fam_of = FAM_CNT;
		end else if (hi == HI_AIN && lo >= LO_AIN_MIN && lo <= LO_AIN_MAX) begin
			fam_of = FAM_AIN;
		end else if (hi == HI_AOUT || hi == HI_DOUT) begin
			fam_of = FAM_OUT;
		end else begin
			fam_of = FAM_NONE;
		end
	endfunction

	function automatic logic [15:0] build_diag(input iosd_cfg_s c, input iosd_raw_s r);
		logic [MAX_CH-1:0] en;
		logic [7:0]        b2;
		logic [7:0]        b4;
		en = '0;
		b2 = 8'h00;
		b4 = 8'h00;
		for (int i = 0; i < MAX_CH; i++) begin
			en[i] = (3'(i) < c.chan_cnt); // [RULE7]
		end
		case (fam_of(c.cfg_id))
			FAM_DIG2: begin
				b2[DIG_CH1_BIT] = r.data[0] & en[0]; // [RULE1]
				b2[DIG_CH2_BIT] = r.data[1] & en[1]; // [RULE1]
			end
			FAM_CNT: begin
				b2[CNT_STATE_BIT] = r.counter;    // [RULE2]
				b2[CNT_INVAL_BIT] = r.inval[0];   // [RULE2]
				b2[CNT_DIR_BIT]   = r.direction;  // [RULE2]
			end
			FAM_AIN: begin
				for (int k = 0; k < 2; k++) begin
					b2[k*CH_STRIDE+UNDER_OFS] = r.under[k] & en[k];       // [RULE3]
					b2[k*CH_STRIDE+INVAL_OFS] = r.inval[k] & en[k];       // [RULE3]
					b4[k*CH_STRIDE+UNDER_OFS] = r.under[k+2] & en[k+2];   // [RULE4]
					b4[k*CH_STRIDE+INVAL_OFS] = r.inval[k+2] & en[k+2];   // [RULE4]
				end
			end
			FAM_OUT: begin
				for (int k = 0; k < 2; k++) begin
					b2[k*CH_STRIDE+INVAL_OFS] = r.inval[k] & en[k];       // [RULE5]
					b4[k*CH_STRIDE+INVAL_OFS] = r.inval[k+2] & en[k+2];   // [RULE5]
				end
			end
			default: begin
				b2 = 8'h00;
			end
		endcase
		if (!c.dual) begin
			b4 = 8'h00; // [RULE6]
		end
		build_diag = {b4, b2};
	endfunction

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	iosd_raw_s [NSLOTS-1:0] s1_q, s1_d;
	iosd_raw_s [NSLOTS-1:0] s2_q, s2_d;
	iosd_raw_s [NSLOTS-1:0] s3_q, s3_d;
	iosd_raw_s [NSLOTS-1:0] flt_q, flt_d;
	iosd_cfg_s [NSLOTS-1:0] cfg_q, cfg_d;
	logic [NSLOTS-1:0]      mis_q, mis_d;
	logic [NSLOTS-1:0]      stat_q, stat_d;
	logic [NSLOTS-1:0]      mask_q, mask_d;
	logic                   irq_q, irq_d;
	logic [DATA_W-1:0]      rdata_q, rdata_d;

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		logic [NSLOTS-1:0] w1c;
		w1c     = '0;
		s1_d    = slot_raw;
		s2_d    = s1_q;
		s3_d    = s2_q;
		flt_d   = flt_q;
		cfg_d   = cfg_q;
		mask_d  = mask_q;
		rdata_d = '0;
		// Pins from the modules settle only once two stages agree
		for (int s = 0; s < NSLOTS; s++) begin
			if (s2_q[s] == s3_q[s]) begin
				flt_d[s] = s3_q[s];
			end
		end
		if (wr_stb) begin
			if (addr == OFF_IRQ_STAT) begin
				w1c = wdata[NSLOTS-1:0];
			end
			if (addr == OFF_IRQ_MASK) begin
				mask_d = wdata[NSLOTS-1:0];
			end
			for (int s = 0; s < NSLOTS; s++) begin
				if (addr == slot_addr(s, SLOT_CFG)) begin
					cfg_d[s] = wdata[$bits(iosd_cfg_s)-1:0];
				end
			end
		end
		for (int s = 0; s < NSLOTS; s++) begin
			mis_d[s] = (cfg_d[s].cfg_id != flt_d[s].plugged_id); // [RULE11]
		end
		// A new mismatch in the clearing cycle still latches
		stat_d = (stat_q & ~w1c) | (mis_d & ~mis_q); // [RULE10]
		irq_d  = |(stat_d & mask_d);
		if (rd_stb) begin
			if (addr == OFF_IRQ_STAT) begin
				rdata_d = DATA_W'(stat_q);
			end
			if (addr == OFF_IRQ_MASK) begin
				rdata_d = DATA_W'(mask_q);
			end
			if (addr == OFF_MISMATCH) begin
				rdata_d = DATA_W'(mis_q);
			end
			for (int s = 0; s < NSLOTS; s++) begin
				if (addr == slot_addr(s, SLOT_CFG)) begin
					rdata_d = DATA_W'(cfg_q[s]);
				end
				if (addr == slot_addr(s, SLOT_TYPE)) begin
					rdata_d = DATA_W'({cfg_q[s].cfg_id, flt_q[s].plugged_id}); // [RULE8]
				end
				if (addr == slot_addr(s, SLOT_DIAG)) begin
					rdata_d = DATA_W'(build_diag(cfg_q[s], flt_q[s]));
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s1_q    <= {NSLOTS{RAW_RST}};
			s2_q    <= {NSLOTS{RAW_RST}};
			s3_q    <= {NSLOTS{RAW_RST}};
			flt_q   <= {NSLOTS{RAW_RST}};
			cfg_q   <= {NSLOTS{CFG_RST}};
			mis_q   <= '0;
			stat_q  <= '0;
			mask_q  <= '0;
			irq_q   <= 1'b0;
			rdata_q <= '0;
		end else begin
			s1_q    <= s1_d;
			s2_q    <= s2_d;
			s3_q    <= s3_d;
			flt_q   <= flt_d;
			cfg_q   <= cfg_d;
			mis_q   <= mis_d;
			stat_q  <= stat_d;
			mask_q  <= mask_d;
			irq_q   <= irq_d;
			rdata_q <= rdata_d;
		end
	end

	assign rdata         = rdata_q;
	assign slot_mismatch = mis_q;
	assign irq           = irq_q;

endmodule

/* File: design/iosd_pkg.sv */
package iosd_pkg;

	// ---------------------------------------------------------------
	// Register bus
	// ---------------------------------------------------------------
	localparam int          ADDR_W        = 12;
	localparam int          DATA_W        = 32;
	localparam logic [11:0] OFF_IRQ_STAT  = 12'h000;
	localparam logic [11:0] OFF_IRQ_MASK  = 12'h004;
	localparam logic [11:0] OFF_MISMATCH  = 12'h008;
	localparam logic [11:0] OFF_SLOT_BASE = 12'h100;
	localparam int          SLOT_SH       = 4;
	localparam logic [11:0] SLOT_CFG      = 12'h000;
	localparam logic [11:0] SLOT_TYPE     = 12'h004;
	localparam logic [11:0] SLOT_DIAG     = 12'h008;

	// ---------------------------------------------------------------
	// Identifier digits and module families
	// ---------------------------------------------------------------
	localparam logic [3:0] HI_DIG2     = 4'h6;
	localparam logic [3:0] LO_DIG2     = 4'h1;
	localparam logic [3:0] HI_CNT      = 4'h1;
	localparam logic [3:0] LO_CNT      = 4'h3;
	localparam logic [3:0] HI_AIN      = 4'h3;
	localparam logic [3:0] LO_AIN_MIN  = 4'h1;
	localparam logic [3:0] LO_AIN_MAX  = 4'h5;
	localparam logic [3:0] HI_AOUT     = 4'h4;
	localparam logic [3:0] HI_DOUT     = 4'h5;

	typedef enum logic [4:0] {
		FAM_NONE = 5'h01,
		FAM_DIG2 = 5'h02,
		FAM_CNT  = 5'h04,
		FAM_AIN  = 5'h08,
		FAM_OUT  = 5'h10
	} iosd_fam_e;

	// ---------------------------------------------------------------
	// Diagnostic byte layout
	// ---------------------------------------------------------------
	localparam int DIG_CH1_BIT   = 0;
	localparam int DIG_CH2_BIT   = 1;
	localparam int CNT_STATE_BIT = 0;
	localparam int CNT_INVAL_BIT = 1;
	localparam int CNT_DIR_BIT   = 3;
	localparam int UNDER_OFS     = 0;
	localparam int INVAL_OFS     = 1;
	localparam int CH_STRIDE     = 4;
	localparam int MAX_CH        = 4;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic       dual;
		logic [2:0] chan_cnt;
		logic [7:0] cfg_id;
	} iosd_cfg_s;

	localparam iosd_cfg_s CFG_RST = 12'h000;

	typedef struct packed {
		logic [7:0] plugged_id;
		logic       counter;
		logic       direction;
		logic [3:0] under;
		logic [3:0] inval;
		logic [3:0] data;
	} iosd_raw_s;

	localparam iosd_raw_s RAW_RST = 22'h000000;

endpackage

/* File: sim/iosd_reader.sv */
`timescale 1ns/1ns
module iosd_reader
	import iosd_pkg::*;
(
	input  wire logic              clock,
	output logic      [ADDR_W-1:0] addr,
	output logic      [DATA_W-1:0] wdata,
	output logic                   wr_stb,
	output logic                   rd_stb,
	input  wire logic [DATA_W-1:0] rdata
);
	// ----------------
	// Bus master tasks
	// ----------------
	initial {addr, wdata, wr_stb, rd_stb} = '0;
	// Idle cycle at the end so a strobe is never set twice in one step
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		addr <= a;
		wdata <= d;
		wr_stb <= w;
		rd_stb <= !w;
		@(posedge clock);
		wr_stb <= 1'b0;
		rd_stb <= 1'b0;
		@(negedge clock);
		q = rdata;
		@(posedge clock);
	endtask
	task automatic pair(output logic mm);
		logic [31:0] q;
		acc(1'b0, 12'h104, '0, q);
		mm = q[15:8] != q[7:0];
	endtask
endmodule

/* File: sim/iosd_checker.sv */
`timescale 1ns/1ns
module iosd_checker
	import iosd_pkg::*;
#(parameter int NSLOTS = 8) (
	input wire logic                   clock,
	input wire logic                   rst_n,
	input wire logic [ADDR_W-1:0]      addr,
	input wire logic [DATA_W-1:0]      wdata,
	input wire logic                   wr_stb,
	input wire logic                   rd_stb,
	input wire logic [DATA_W-1:0]      rdata,
	input wire iosd_raw_s [NSLOTS-1:0] slot_raw,
	input wire logic [NSLOTS-1:0]      slot_mismatch,
	input wire logic                   irq
);
	// ----------
	// Properties
	// ----------
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire logic rd_slot = rd_stb && addr[11:8] == 4'h1;
	property p_idle; !$past(rd_stb) |-> rdata == '0; endproperty
	a_idle: assert property (p_idle) else $error("rdata not idle");
	property p_resv; rd_slot && addr[3:0] == 4'h8 |=> (rdata & 32'hffffc4c4) == '0; endproperty
	a_resv: assert property (p_resv) else $error("reserved diag bit set");
	property p_type; rd_slot && addr[3:0] == 4'h4 |=> rdata[31:16] == '0; endproperty
	a_type: assert property (p_type) else $error("type upper bits set");
	// Six quiet samples cover the pin filter delay
	property p_plug;
		($stable(slot_raw[0]))[*6] ##0 (rd_stb && addr == 12'h104)
			|=> rdata[7:0] == $past(slot_raw[0].plugged_id);
	endproperty
	a_plug: assert property (p_plug) else $error("plugged id wrong");
	property p_mmrd; rd_stb && addr == 12'h008 |=> rdata == 32'($past(slot_mismatch)); endproperty
	a_mmrd: assert property (p_mmrd) else $error("mismatch read wrong");
	property p_strd; rd_stb && addr == 12'h000 |=> (rdata >> NSLOTS) == '0; endproperty
	a_strd: assert property (p_strd) else $error("status upper bits set");
	property p_irqup;
		$rose(irq) |-> $past(wr_stb) || (slot_mismatch & ~$past(slot_mismatch)) != '0;
	endproperty
	a_irqup: assert property (p_irqup) else $error("irq rose without cause");
	property p_irqdn; $fell(irq) |-> $past(wr_stb); endproperty
	a_irqdn: assert property (p_irqdn) else $error("irq fell without write");
	c_irq: cover property ($rose(irq));
	c_mm: cover property ($rose(slot_mismatch[0]));
	c_diag: cover property (rd_slot && addr[3:0] == 4'h8 ##1 rdata[15:8] != '0);
endmodule

/* File: sim/io_slot_diagnostic_status_tb_top.sv */
`timescale 1ns/1ns
module io_slot_diagnostic_status_tb_top import iosd_pkg::*;;
	logic              clock = 1'b0;
	logic              rst_n = 1'b0;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata, q;
	logic              wr_stb, rd_stb, irq, mm;
	logic [1:0]        slot_mismatch;
	iosd_raw_s [1:0]   slot_raw = '0;
	int                error_cnt = 0, n_tests = 0, cyc = 0;
	// Row: cfg word, plugged id, expected diag; pins all high so masking shows
	logic [35:0]       rows [8] = '{36'h261610003, 36'h01313000b, 36'hc33333333,
		36'h235350033, 36'hc41412222, 36'hb52520222, 36'h131310003, 36'h42c450000};
	iosd_reader m (.clock, .addr, .wdata, .wr_stb, .rd_stb, .rdata);
	iosd_slot_diag #(.NSLOTS(2)) uut (.clock, .rst_n, .addr, .wdata, .wr_stb, .rd_stb,
		.rdata, .slot_raw, .slot_mismatch, .irq);
	task automatic chk(input string n, input logic [31:0] e, s);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", n, e, s);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 1000) begin
			error_cnt++;
			finish_test();
		end
	end
	// --------
	// Sequence
	// --------
	initial begin
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		m.acc(1'b0, 12'h100, '0, q);
		chk("reset", '0, {q[30:0], irq});
		foreach (rows[i]) begin
			m.acc(1'b1, 12'h100, 32'(rows[i][35:24]), q);
			slot_raw[0] <= {rows[i][23:16], 14'h3fff};
			repeat (6) @(posedge clock);
			m.acc(1'b0, 12'h108, '0, q);
			chk("diag", 32'(rows[i][15:0]), q);
			m.acc(1'b0, 12'h104, '0, q);
			chk("type", 32'(rows[i][31:16]), q);
			m.pair(mm);
			chk("mismatch", {2{rows[i][31:24] != rows[i][23:16]}}, {mm, slot_mismatch[0]});
			$display("row %0d done", i);
		end
		m.acc(1'b1, 12'h000, 32'hff, q);
		m.acc(1'b1, 12'h004, 32'h1, q);
		chk("irq masked", '0, 32'(irq));
		slot_raw[0].plugged_id <= 8'h2c;
		repeat (6) @(posedge clock);
		slot_raw[0].plugged_id <= 8'h45;
		repeat (6) @(posedge clock);
		chk("irq", 32'h1, 32'(irq));
		m.acc(1'b0, 12'h000, '0, q);
		chk("status", 32'h1, q);
		m.acc(1'b0, 12'h008, '0, q);
		chk("mismatch reg", 32'h1, q);
		m.acc(1'b1, 12'h000, 32'h1, q);
		chk("irq clear", '0, 32'(irq));
		m.acc(1'b1, 12'h104, '0, q);
		m.acc(1'b0, 12'h104, '0, q);
		chk("type ro", 32'h2c45, q);
		m.acc(1'b0, 12'h00c, '0, q);
		chk("unmapped", '0, q);
		$display("irq and access tests done");
		// Distinct pin levels so swapped or shifted fields show up
		m.acc(1'b1, 12'h100, 32'h0c33, q);
		slot_raw[0] <= {8'h33, 1'b1, 1'b0, 4'b0101, 4'b1010, 4'b1111};
		repeat (6) @(posedge clock);
		m.acc(1'b0, 12'h108, '0, q);
		chk("diag ain mixed", 32'h2121, q);
		m.acc(1'b1, 12'h100, 32'h0013, q);
		slot_raw[0] <= {8'h13, 1'b1, 1'b0, 4'b1111, 4'b0001, 4'b0000};
		repeat (6) @(posedge clock);
		m.acc(1'b0, 12'h108, '0, q);
		chk("diag cnt mixed", 32'h0003, q);
		m.acc(1'b1, 12'h100, 32'h0261, q);
		slot_raw[0] <= {8'h61, 1'b0, 1'b1, 4'b0000, 4'b0000, 4'b0010};
		repeat (6) @(posedge clock);
		m.acc(1'b0, 12'h108, '0, q);
		chk("diag dig mixed", 32'h0002, q);
		$display("mixed pin tests done");
		// Reset again in mid-run: configuration and interrupt must return to zero
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		m.acc(1'b0, 12'h100, '0, q);
		chk("reset again", '0, {q[30:0], irq});
		$display("second reset test done");
		finish_test();
	end
endmodule
bind iosd_slot_diag iosd_checker #(.NSLOTS(NSLOTS)) chk_i (.clock, .rst_n, .addr, .wdata,
	.wr_stb, .rd_stb, .rdata, .slot_raw, .slot_mismatch, .irq);
